/* File: core/bbat_regs.vh */
`ifndef BBAT_REGS_VH
`define BBAT_REGS_VH
// Register numbers on the system control coprocessor move port
`define BBAT_REG_INSTR_SPACE_BASE     5'h00
`define BBAT_REG_INSTR_SPACE_BOUND    5'h01
`define BBAT_REG_DATA_SPACE_BASE     5'h02
`define BBAT_REG_DATA_SPACE_BOUND    5'h03
`define BBAT_REG_POLICY    5'h11
// Page field of base and bound registers
`define BBAT_PAGE_HI       31
`define BBAT_PAGE_LO       12
`define BBAT_LIM_HI        30
`define BBAT_OFS_HI        11
`define BBAT_RSVD_ZERO     12'h000
`define BBAT_RSVD_TOP      1'b0
`define BBAT_READ_ZERO     32'h00000000
`define BBAT_VA_HI         31
// Reset images of base and bound page fields
`define BBAT_BASE_RESET    20'h00000
`define BBAT_BOUND_RESET   19'h00000
// Segment selectors on virtual bits 31:29
`define BBAT_SEG_KSEG_A    3'h4
`define BBAT_SEG_KSEG_B    3'h5
`define BBAT_SEG_USER_0    3'h0
`define BBAT_SEG_USER_1    3'h1
`define BBAT_SEG_USER_2    3'h2
`define BBAT_SEG_USER_3    3'h3
`define BBAT_SEG_UPPER_0   3'h6
`define BBAT_SEG_UPPER_1   3'h7
`define BBAT_SEG_ZERO      3'h0
`define BBAT_SEG_HI        31
`define BBAT_SEG_LO        29
`define BBAT_SEG_B_OFFSET  32'ha0000000
// Cache policy register: 8 regions of 4 bits, bit 3 of each unimplemented
`define BBAT_POLICY_RESET  32'h22233333
`define BBAT_POLICY_MASK   32'h77777777
`define BBAT_POLICY_W      4
`endif

/* File: core/bbat_translator.v */
`timescale 1ns/1ps
// Contract
// RULE1 - User mode only when unprivileged bit set and both level bits clear.
// RULE2 - Kernel mode when unprivileged bit clear or either level bit set.
// RULE3 - User access with virtual bit 31 set raises address error.
// RULE4 - User segment translated identically from user and kernel mode.
// RULE5 - Kernel access with bit 31 clear is relocated and bound checked.
// RULE6 - Top bits 100 bypass mapping; physical is zeros with bits 28:0.
// RULE7 - Top bits 101 bypass mapping; physical is virtual minus a0000000.
// RULE8 - After reset segment a cacheable, segment b uncached.
// RULE9 - Top bits 11 map to zeros with bits 28:0.
// RULE10 - Every segment cacheability comes from the cache policy register.
// RULE11 - Exception forces kernel mode until return restores prior mode.
// RULE12 - Instruction base upper 20 bits relocate fetches; low 12 read zero.
// RULE13 - Fetch above instruction bound raises address error, no access.
// RULE14 - Data base relocates loads and stores; low 12 read zero.
// RULE15 - Data addresses checked against separate data bound.
// RULE16 - Software writes zero into reserved low bits.
// RULE17 - Compare virtual bits 30:12 with bound 30:12; greater is error.
// RULE18 - Physical is 20-bit page sum with bits 11:0 unchanged.
// RULE19 - Address bits 63:32 discarded before translation.
// RULE20 - Fetch uses instruction pair, data uses data pair, same cycle.
`include "bbat_regs.vh"

// Register numbers on the move port:
//   instruction base and bound, data base and bound, then cache policy.
// Reads are combinational, so a read sees a write from the cycle before.
// Outputs are combinational on purpose: translation must fit the access
// cycle, which is why the translated address is not registered here.
// No interrupt and no exception sequencing: refusals are level outputs
// that the pipeline turns into its own exceptions.

module bbat_translator #(
   parameter VA_W = 64
) (
   input  wire            clk,
   input  wire            resetn,
   // Status bits as held by the pipeline
   input  wire            unprivileged_select_bit,
   input  wire            exception_level_bit,
   input  wire            error_level_bit,
   // Coprocessor move port
   input  wire            reg_wr,
   input  wire [4:0]      reg_num,
   input  wire [31:0]     reg_wdata,
   output reg  [31:0]     reg_rdata,
   // Instruction fetch path
   input  wire            ifetch_valid,
   input  wire [VA_W-1:0] ifetch_virtual_address,
   output wire            ifetch_phys_valid,
   output wire [31:0]     ifetch_phys_addr,
   output wire [3:0]      ifetch_cache_policy,
   output wire            ifetch_addr_error,
   // Load/store path
   input  wire            data_valid,
   input  wire [VA_W-1:0] data_virtual_address,
   output wire            data_phys_valid,
   output wire [31:0]     data_phys_addr,
   output wire [3:0]      data_cache_policy,
   output wire            data_addr_error,
   // Current mode
   output wire            kernel_mode
);

   // Programmed state; base holds page bits 31:12, bound holds 30:12
   reg  [19:0] instr_space_base_ff;
   reg  [18:0] instr_space_bound_ff;
   reg  [19:0] data_space_base_ff;
   reg  [18:0] data_space_bound_ff;
   reg  [31:0] policy_ff;
   // Next values
   reg  [19:0] nxt_instr_space_base;
   reg  [18:0] nxt_instr_space_bound;
   reg  [19:0] nxt_data_space_base;
   reg  [18:0] nxt_data_space_bound;
   reg  [31:0] nxt_policy;

   // Decoded write strobes and mode terms
   wire        wr_instr_space_base;
   wire        wr_instr_space_bound;
   wire        wr_data_space_base;
   wire        wr_data_space_bound;
   wire        wr_policy;
   wire        user_bit_clear;
   wire        in_exception;
   wire        in_error;
   wire        user_mode;
   wire [31:0] ifetch_va32;
   wire [31:0] data_va32;

   // Any one term is enough for kernel privilege
   assign user_bit_clear = ~unprivileged_select_bit;                   // see RULE2
   assign in_exception   = exception_level_bit;
   assign in_error       = error_level_bit;

   // No mode storage here: exception entry sets a level bit and the
   // return clears it, so the prior mode comes back on its own
   assign kernel_mode    = user_bit_clear | in_exception | in_error;  // see RULE11
   assign user_mode      = ~kernel_mode;                               // see RULE1

   // Only the low word of a 64-bit address takes part in translation
   assign ifetch_va32    = ifetch_virtual_address[`BBAT_VA_HI:0];      // see RULE19
   assign data_va32      = data_virtual_address[`BBAT_VA_HI:0];        // see RULE19

   // Write strobes; numbers outside the table are ignored
   assign wr_instr_space_base  = reg_wr & (reg_num == `BBAT_REG_INSTR_SPACE_BASE);
   assign wr_instr_space_bound = reg_wr & (reg_num == `BBAT_REG_INSTR_SPACE_BOUND);
   assign wr_data_space_base  = reg_wr & (reg_num == `BBAT_REG_DATA_SPACE_BASE);
   assign wr_data_space_bound = reg_wr & (reg_num == `BBAT_REG_DATA_SPACE_BOUND);
   assign wr_policy = reg_wr & (reg_num == `BBAT_REG_POLICY);

   // Next instruction base; low reserved bits are never stored
   always @* begin
      nxt_instr_space_base = instr_space_base_ff;
      if (wr_instr_space_base) begin
         nxt_instr_space_base = reg_wdata[`BBAT_PAGE_HI:`BBAT_PAGE_LO];           // see RULE12
      end
   end

   // Next instruction bound; bit 31 has no storage, user space ends there
   always @* begin
      nxt_instr_space_bound = instr_space_bound_ff;
      if (wr_instr_space_bound) begin
         nxt_instr_space_bound = reg_wdata[`BBAT_LIM_HI:`BBAT_PAGE_LO];           // see RULE13
      end
   end

   // Next data base, kept apart from the fetch pair
   always @* begin
      nxt_data_space_base = data_space_base_ff;
      if (wr_data_space_base) begin
         nxt_data_space_base = reg_wdata[`BBAT_PAGE_HI:`BBAT_PAGE_LO];           // see RULE14
      end
   end

   // Next data bound, independent of the instruction bound
   always @* begin
      nxt_data_space_bound = data_space_bound_ff;
      if (wr_data_space_bound) begin
         nxt_data_space_bound = reg_wdata[`BBAT_LIM_HI:`BBAT_PAGE_LO];           // see RULE15
      end
   end

   // Next cache policy; unimplemented bit of each nibble is dropped
   always @* begin
      nxt_policy = policy_ff;
      if (wr_policy) begin
         nxt_policy = reg_wdata & `BBAT_POLICY_MASK;                    // see RULE10
      end
   end

   // Register update; reset leaves page zero as the only legal user page
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         instr_space_base_ff  <= `BBAT_BASE_RESET;
         instr_space_bound_ff <= `BBAT_BOUND_RESET;
         data_space_base_ff  <= `BBAT_BASE_RESET;
         data_space_bound_ff <= `BBAT_BOUND_RESET;
         policy_ff <= `BBAT_POLICY_RESET;                               // see RULE8
      end else begin
         instr_space_base_ff  <= nxt_instr_space_base;
         instr_space_bound_ff <= nxt_instr_space_bound;
         data_space_base_ff  <= nxt_data_space_base;
         data_space_bound_ff <= nxt_data_space_bound;
         policy_ff <= nxt_policy;
      end
   end

   // Read images; reserved low bits always read as zero
   wire [31:0] instr_space_base_img  = {instr_space_base_ff, `BBAT_RSVD_ZERO};                 // see RULE12
   wire [31:0] instr_space_bound_img = {`BBAT_RSVD_TOP, instr_space_bound_ff, `BBAT_RSVD_ZERO};
   wire [31:0] data_space_base_img  = {data_space_base_ff, `BBAT_RSVD_ZERO};                 // see RULE14
   wire [31:0] data_space_bound_img = {`BBAT_RSVD_TOP, data_space_bound_ff, `BBAT_RSVD_ZERO};

   // Read mux; unused numbers read as zero
   always @* begin
      case (reg_num)
         `BBAT_REG_INSTR_SPACE_BASE:  reg_rdata = instr_space_base_img;
         `BBAT_REG_INSTR_SPACE_BOUND: reg_rdata = instr_space_bound_img;
         `BBAT_REG_DATA_SPACE_BASE:  reg_rdata = data_space_base_img;
         `BBAT_REG_DATA_SPACE_BOUND: reg_rdata = data_space_bound_img;
         `BBAT_REG_POLICY: reg_rdata = policy_ff;
         default:          reg_rdata = `BBAT_READ_ZERO;
      endcase
   end

   // One translator per path, each with its own pair
   bbat_xlate u_ixl (
      .user_mode (user_mode),
      .req       (ifetch_valid),
      .va        (ifetch_va32),
      .base      (instr_space_base_ff),                                   // see RULE20
      .bound     (instr_space_bound_ff),
      .policy    (policy_ff),
      .pa_valid  (ifetch_phys_valid),
      .pa        (ifetch_phys_addr),
      .cpol      (ifetch_cache_policy),
      .addr_err  (ifetch_addr_error)                           // see RULE13
   );

   // Load/store path sees only the data pair
   bbat_xlate u_dxl (
      .user_mode (user_mode),
      .req       (data_valid),
      .va        (data_va32),
      .base      (data_space_base_ff),                                   // see RULE20
      .bound     (data_space_bound_ff),
      .policy    (policy_ff),
      .pa_valid  (data_phys_valid),
      .pa        (data_phys_addr),
      .cpol      (data_cache_policy),
      .addr_err  (data_addr_error)                             // see RULE15
   );

endmodule

// Combinational translation of one address; finishes within the cycle.
// Limitations a user should know:
//   the bound compare is unsigned and inclusive, so the bound page is legal;
//   the mapped sum wraps at 20 bits with no overflow error;
//   exception sequencing is left to the pipeline, which owns the level bits.
module bbat_xlate (
   // Mode and request
   input  wire        user_mode,
   input  wire        req,
   input  wire [31:0] va,
   // Programmed state
   input  wire [19:0] base,
   input  wire [18:0] bound,
   input  wire [31:0] policy,
   // Results
   output wire        pa_valid,
   output reg  [31:0] pa,
   output wire [3:0]  cpol,
   output wire        addr_err
);
   // Segment decode
   wire [2:0]  seg;
   wire        kern_va;
   wire        seg_user;

   // Relocation and fixed maps
   wire        over;
   wire [19:0] page;
   wire [31:0] mapped_pa;
   wire [31:0] fixed_pa;
   wire [31:0] shifted_pa;

   // Refusal terms
   wire        priv_err;
   wire        bound_err;
   wire        err;

   // Segment decode on the top three virtual bits
   assign seg      = va[`BBAT_SEG_HI:`BBAT_SEG_LO];
   assign kern_va  = va[`BBAT_SEG_HI];
   assign seg_user = ~kern_va;                                      // see RULE4

   // Bound check on page bits below bit 31; equal page still passes
   assign over = va[`BBAT_LIM_HI:`BBAT_PAGE_LO] > bound;            // see RULE17

   // Relocation wraps at 20 bits, so a page sum past the top folds back to low pages
   assign page      = va[`BBAT_PAGE_HI:`BBAT_PAGE_LO] + base;       // see RULE18
   assign mapped_pa = {page, va[`BBAT_OFS_HI:0]};                   // see RULE5

   // Unmapped kernel segments drop the top three bits
   assign fixed_pa   = {`BBAT_SEG_ZERO, va[`BBAT_SEG_LO-1:0]};      // see RULE6 see RULE9
   assign shifted_pa = va - `BBAT_SEG_B_OFFSET;                     // see RULE7

   // Privileged reach from user mode and a bound overrun both refuse
   assign priv_err  = kern_va & user_mode;                          // see RULE3
   assign bound_err = seg_user & over;                              // see RULE13 see RULE15
   assign err       = priv_err | bound_err;

   // Outputs qualified by the request so an idle path shows no error
   assign addr_err = req & err;                                     // see RULE20
   assign pa_valid = req & ~err;

   // Policy nibble chosen by region, in parallel with translation
   assign cpol = policy[seg*`BBAT_POLICY_W +: `BBAT_POLICY_W];      // see RULE10

   // Address chosen by segment; user and kernel share the mapped path
   always @* begin
      case (seg)
         `BBAT_SEG_USER_0,
         `BBAT_SEG_USER_1,
         `BBAT_SEG_USER_2,
         `BBAT_SEG_USER_3: begin
            pa = mapped_pa;                                         // see RULE4
         end
         `BBAT_SEG_KSEG_A: begin
            pa = fixed_pa;                                          // see RULE6
         end
         `BBAT_SEG_KSEG_B: begin
            pa = shifted_pa;                                        // see RULE7
         end
         `BBAT_SEG_UPPER_0,
         `BBAT_SEG_UPPER_1: begin
            pa = fixed_pa;                                          // see RULE9
         end
         default: begin
            pa = fixed_pa;
         end
      endcase
   end
endmodule

/* File: sim/bbat_pipe_model.sv */
`timescale 1ns/1ps
module bbat_pipe_model (
   input  wire        clk,
   input  wire        go,
   input  wire [63:0] cmd_va,
   output reg         valid = 1'b0,
   output reg  [63:0] va = 64'h0);
   // Idle address flips so a stale value never looks valid
   always @(posedge clk) begin
      valid <= go;
      va    <= go ? cmd_va : ~va;
   end
endmodule

/* File: sim/bbat_translator_asserts.sv */
`timescale 1ns/1ps
module bbat_translator_asserts #(parameter VA_W = 64) (
   input wire clk, resetn, unprivileged_select_bit, exception_level_bit, error_level_bit,
   input wire reg_wr, input wire [4:0] reg_num, input wire [31:0] reg_wdata, reg_rdata,
   input wire ifetch_valid, ifetch_phys_valid, ifetch_addr_error, data_valid,
   input wire data_phys_valid, data_addr_error, kernel_mode,
   input wire [VA_W-1:0] ifetch_virtual_address, data_virtual_address,
   input wire [31:0] ifetch_phys_addr, data_phys_addr,
   input wire [3:0] ifetch_cache_policy, data_cache_policy);
   wire [31:0] iv = ifetch_virtual_address[31:0];
   wire [31:0] dv = data_virtual_address[31:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_mode_decode:
   assert property (kernel_mode == !(unprivileged_select_bit && !exception_level_bit
      && !error_level_bit)) else $error("mode");
   a_user_high_err:
   assert property (ifetch_valid && !kernel_mode && iv[31] |-> ifetch_addr_error
      && !ifetch_phys_valid) else $error("user high");
   a_kseg_a_map:
   assert property (ifetch_valid && kernel_mode && iv[31:29] == 3'h4 |-> ifetch_phys_valid
      && ifetch_phys_addr == {3'h0, iv[28:0]}) else $error("seg a");
   a_kseg_b_map:
   assert property (data_valid && kernel_mode && dv[31:29] == 3'h5 |-> data_phys_valid
      && data_phys_addr == dv - 32'ha0000000) else $error("seg b");
   a_reg_write:
   assert property ((reg_wr && reg_num < 5'h04) ##1 reg_num == $past(reg_num) |-> reg_rdata
      == ($past(reg_wdata) & (reg_num[0] ? 32'h7ffff000 : 32'hfffff000))) else $error("wr");
   a_policy_pick:
   assert property (ifetch_valid && reg_num == 5'h11 |-> ifetch_cache_policy
      == reg_rdata[{iv[31:29], 2'h0} +: 4]) else $error("policy");
   a_ireloc_sum:
   assert property (ifetch_valid && !iv[31] && !ifetch_addr_error && reg_num == 5'h00
      |-> ifetch_phys_addr == {iv[31:12] + reg_rdata[31:12], iv[11:0]}) else $error("sum");
   a_data_space_bound_cmp:
   assert property (data_valid && !dv[31] && reg_num == 5'h03 |-> data_addr_error
      == (dv[30:12] > reg_rdata[30:12]) && data_phys_valid != data_addr_error)
      else $error("bound");
endmodule
bind bbat_translator bbat_translator_asserts #(.VA_W(VA_W)) u_chk (.*);

/* File: sim/bbat_translator_bench.sv */
`timescale 1ns/1ps
module bbat_translator_bench;
   reg         clk = 1'b0, resetn = 1'b0, go = 1'b0, wr = 1'b0;
   reg  [2:0]  st = 3'h1;
   reg  [4:0]  num = 5'h11;
   reg  [31:0] wd = 32'h0, v, sh [0:3], pol = 32'h22233333;
   reg  [63:0] cva = 64'h0;
   wire [63:0] iva, dva;
   wire [31:0] rd, ipa, dpa;
   wire [3:0]  ipol, dpol;
   wire        iv, ie, ipv, dv, de, dpv, km;
   integer     mismatches = 0, cmp_count = 0, cyc = 0, n, k;
   always #50 clk = ~clk;
   bbat_pipe_model u_if (.clk(clk), .go(go), .cmd_va(cva), .valid(iv), .va(iva));
   bbat_pipe_model u_ld (.clk(clk), .go(go), .cmd_va(cva), .valid(dv), .va(dva));
   bbat_translator dut (.clk(clk), .resetn(resetn), .unprivileged_select_bit(st[0]),
      .exception_level_bit(st[1]), .error_level_bit(st[2]), .reg_wr(wr), .reg_num(num),
      .reg_wdata(wd), .reg_rdata(rd), .ifetch_valid(iv), .ifetch_virtual_address(iva),
      .ifetch_phys_valid(ipv), .ifetch_phys_addr(ipa), .ifetch_cache_policy(ipol),
      .ifetch_addr_error(ie), .data_valid(dv), .data_virtual_address(dva),
      .data_phys_valid(dpv), .data_phys_addr(dpa), .data_cache_policy(dpol),
      .data_addr_error(de), .kernel_mode(km));
   task check(input [63:0] seen, input [63:0] want);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   // Expected {error, physical address}; only user mode is st == 1
   function [32:0] xl(input [31:0] a, input [31:0] bs, input [31:0] bd);
      if (a[31]) xl = st == 3'h1 ? {1'b1, 32'h0} : {1'b0, 3'h0, a[28:0]};
      else if (a[30:12] > bd[30:12]) xl = {1'b1, 32'h0};
      else xl = {1'b0, a[31:12] + bs[31:12], a[11:0]};
   endfunction
   task acc(input [31:0] a, input [2:0] s);
      reg [32:0] xi, xd;
      begin
         @(posedge clk);
         cva <= {$urandom, a};
         st <= s;
         @(posedge clk);
         @(negedge clk);
         xi = xl(a, sh[0], sh[1]);
         xd = xl(a, sh[2], sh[3]);
         check(km, st != 3'h1);
         check({ie, ipv, ie ? 32'h0 : ipa, ipol},
            {xi[32], !xi[32], xi[31:0], pol[{a[31:29], 2'h0} +: 4]});
         check({de, dpv, de ? 32'h0 : dpa, dpol},
            {xd[32], !xd[32], xd[31:0], pol[{a[31:29], 2'h0} +: 4]});
      end
   endtask
   task wreg(input [4:0] r, input [31:0] d);
      reg [31:0] w;
      begin
         @(posedge clk);
         wr <= 1'b1;
         num <= r;
         wd <= r < 5'h4 ? d & 32'hfffff000 : d;
         @(posedge clk);
         wr <= 1'b0;
         @(negedge clk);
         w = r == 5'h11 ? d & 32'h77777777 : r > 5'h3 ? 32'h0 :
            d & (r[0] ? 32'h7ffff000 : 32'hfffff000);
         if (r < 5'h4) sh[r[1:0]] = w;
         if (r == 5'h11) pol = w;
         check(rd, w);
      end
   endtask
   task complete_run;
      begin
         $display("Compares %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   // Random traffic over all segments and modes, bound edges forced
   initial begin
      for (n = 0; n < 4; n = n + 1) sh[n] = 32'h0;
      n = $urandom(96);
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      go <= 1'b1;
      @(negedge clk);
      check(rd, 32'h22233333);
      for (n = 0; n < 400; n = n + 1) begin
         k = $urandom % 8;
         if (k < 6) wreg(k < 4 ? k : k == 4 ? 5'h11 : $urandom, $urandom);
         v = $urandom;
         v[31:29] = n[2:0];
         if (n[3]) v[30:12] = sh[k % 2 * 2 + 1][30:12] + n[4];
         acc(v, $urandom);
      end
      complete_run;
   end
endmodule
